/* File: core/dmba_regs.svh */
// Register offsets, field positions, reset values and settings of the arbiter.
// Assumes APB byte addressing with one aligned 32-bit word per register.
`ifndef DMBA_REGS_SVH
`define DMBA_REGS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define DMBA_PRIO_CTRL_OFFSET  12'h000   // Priority control register
`define DMBA_STATUS_OFFSET     12'h004   // Grant and pending status
`define DMBA_ADDR_W            12        // Decoded address bits

// ****************************************************************
// Fields and values
// ****************************************************************
`define DMBA_PRIO_CTRL_RESET   16'h0000  // Default order, CPU on top
`define DMBA_PRIO_DMA_RAISED   16'h0020  // DMA above CPU
`define DMBA_NUM_MASTERS       3         // CPU, DMA, debug
`define DMBA_IDX_CPU           0         // Requester index of CPU
`define DMBA_IDX_DMA           1         // Requester index of DMA
`define DMBA_IDX_DBG           2         // Requester index of debug

`endif

/* File: core/dmba_pkg.sv */
// Types shared by the data memory bus arbiter files.
// Assumes dmba_regs.svh is compiled alongside.
package dmba_pkg;

    // Three-bit per-master vector: bit 0 CPU, bit 1 DMA, bit 2 debug
    typedef logic [2:0] dmba_vec_t;

    // Request and done strobes from the three masters
    typedef struct packed {
        dmba_vec_t req;   // Level requests, held until granted and done
        dmba_vec_t done;  // Access finished, one-cycle pulse
    } dmba_mreq_t;

    // Arbiter states
    typedef enum logic [1:0] {
        DMBA_IDLE,
        DMBA_BUSY
    } dmba_state_t;

endpackage

/* File: core/dmba_pick.sv */
// Combinational priority picker for the three bus masters.
// Assumes the caller registers its result.
`include "dmba_regs.svh"

module dmba_pick (
    input  wire logic              dma_raised,  // DMA above CPU when set
    input  wire dmba_pkg::dmba_vec_t req,       // Pending requests
    output      dmba_pkg::dmba_vec_t win        // One-hot winner or zero
);
    // ****************************************************************
    // Fixed priority with optional DMA promotion
    // ****************************************************************
    always_comb
    begin
        win = 3'h0;
        if (dma_raised && req[`DMBA_IDX_DMA])
            win[`DMBA_IDX_DMA] = 1'b1;
        else if (req[`DMBA_IDX_CPU])
            win[`DMBA_IDX_CPU] = 1'b1;
        else if (!dma_raised && req[`DMBA_IDX_DMA])
            win[`DMBA_IDX_DMA] = 1'b1;
        else if (req[`DMBA_IDX_DBG])
            win[`DMBA_IDX_DBG] = 1'b1;
    end
endmodule // dmba_pick

/* File: core/dmba_arbiter.sv */
// Data memory bus arbiter with an APB priority control register.
// Assumes masters hold req high until their done pulse after grant.
//
// Notes on behaviour
// - Arbitrate all data memory among three masters
// - Coincident requests: only highest priority granted
// - Losers stall with request kept pending
// - Default order puts CPU at top
// - Debug lowest; DMA second by default
// - Levels one and two unused by default
// - Value 0x0020 raises DMA above CPU
// - Raised masters keep their relative order
// - Lower masters keep their relative order
// - Priority writable at any time
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`include "dmba_regs.svh"

module dmba_arbiter (
    input  wire logic                 pclk,       // System clock, 20 MHz
    input  wire logic                 presetn,    // Async reset, active low
    input  wire logic                 psel,       // APB select
    input  wire logic                 penable,    // APB access phase
    input  wire logic                 pwrite,     // APB direction
    input  wire logic [11:0]          paddr,      // APB byte address
    input  wire logic [31:0]          pwdata,     // APB write data
    input  wire logic [3:0]           pstrb,      // APB byte strobes
    output      logic [31:0]          prdata,     // APB read data
    output      logic                 pready,     // APB ready
    output      logic                 pslverr,    // APB error
    input  wire dmba_pkg::dmba_mreq_t mreq,       // Master requests and done
    output      dmba_pkg::dmba_vec_t  grant       // One-hot bus grant
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        dmba_pkg::dmba_state_t state;     // Arbiter state
        dmba_pkg::dmba_vec_t   grant;     // Current owner
        logic [15:0]           prio;      // Priority control register
        logic [31:0]           prdata;    // Read data
        logic                  pready;    // Ready
        logic                  pslverr;   // Error
    } dmba_st_t;

    dmba_st_t            st;              // Registered state
    dmba_st_t            next_st;         // Next state
    dmba_pkg::dmba_vec_t win;             // Picker result
    logic                dma_raised;      // Decoded priority mode
    logic                setup;           // APB setup seen
    logic                hit_prio;        // Address hits priority register
    logic                hit_stat;        // Address hits status register
    logic                complete;        // Completing edge of an access

    // Only the exact raise code promotes the DMA
    // Reserved codes fall back to the default order
    assign dma_raised = (st.prio == `DMBA_PRIO_DMA_RAISED);
    // Setup is the first cycle of a transfer
    assign setup      = psel && !penable;
    // Access phase ends where this slave shows ready
    assign complete   = psel && penable && st.pready;
    assign hit_prio   = (paddr == `DMBA_PRIO_CTRL_OFFSET);
    assign hit_stat   = (paddr == `DMBA_STATUS_OFFSET);

    // ****************************************************************
    // Picker
    // ****************************************************************
    dmba_pick u_pick (
        .dma_raised (dma_raised),
        .req        (mreq.req),
        .win        (win)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        next_st         = st;
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        // Arbitration
        case (st.state)
            dmba_pkg::DMBA_IDLE:
            begin
                // Decide among all pending requests
                if (win != 3'h0)
                begin
                    next_st.grant = win;
                    next_st.state = dmba_pkg::DMBA_BUSY;
                end
            end
            dmba_pkg::DMBA_BUSY:
            begin
                // Owner keeps the bus until done; losers wait
                if ((mreq.done & st.grant) != 3'h0)
                begin
                    next_st.grant = 3'h0;
                    next_st.state = dmba_pkg::DMBA_IDLE;
                end
            end
            default:
            begin
                next_st.grant = 3'h0;
                next_st.state = dmba_pkg::DMBA_IDLE;
            end
        endcase
        // APB: answer in the cycle after setup, no wait states
        if (setup)
        begin
            next_st.pready = 1'b1;
            if (pwrite)
            begin
                // Writes to the status word are ignored quietly
                if (!hit_prio && !hit_stat)
                    next_st.pslverr = 1'b1;
            end
            else if (hit_prio)
                // Upper half of the word reads as zero
                next_st.prdata = {16'h0000, st.prio};
            else if (hit_stat)
                // Pending requests in [5:3], owner in [2:0]
                next_st.prdata = {26'h0, mreq.req, st.grant};
            else
            begin
                // Unmapped read: zero data and an error
                next_st.prdata  = 32'h0000_0000;
                next_st.pslverr = 1'b1;
            end
        end
        // Write lands only at the completing edge of the access phase
        if (complete && pwrite && hit_prio)
        begin
            // Accepted at any time; used at the next decision only
            if (pstrb[0])
                next_st.prio[7:0] = pwdata[7:0];
            // Upper byte has its own strobe
            if (pstrb[1])
                next_st.prio[15:8] = pwdata[15:8];
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st.state   <= dmba_pkg::DMBA_IDLE;
            st.grant   <= 3'h0;
            st.prio    <= `DMBA_PRIO_CTRL_RESET;
            st.prdata  <= 32'h0000_0000;
            st.pready  <= 1'b0;
            st.pslverr <= 1'b0;
        end
        else
            st <= next_st;
    end

    // Outputs come straight from the state flops
    assign prdata  = st.prdata;
    assign pready  = st.pready;
    assign pslverr = st.pslverr;
    assign grant   = st.grant;

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Every check runs on the system clock and sleeps during reset

    // First cycle of an APB transfer
    sequence s_setup;
        psel && !penable;
    endsequence

    // Completing edge of an APB transfer
    sequence s_complete;
        psel && penable && pready;
    endsequence

    // Arbiter idle with at least one pending request
    sequence s_decide;
        st.state == dmba_pkg::DMBA_IDLE && mreq.req != 3'h0;
    endsequence

    // Current owner closes its access
    sequence s_owner_done;
        grant != 3'h0 && (mreq.done & grant) != 3'h0;
    endsequence

    // Never more than one owner at a time
    AST_ONEHOT: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(grant))
        else $error("Grant not one-hot");

    // Default order: a requesting CPU wins the decision
    AST_CPU_TOP: assert property (@(posedge pclk) disable iff (!presetn)
        (st.state == dmba_pkg::DMBA_IDLE && !dma_raised && mreq.req[0])
        |=> grant == 3'h1)
        else $error("CPU not granted first");

    // Raised order: a requesting DMA wins the decision
    AST_DMA_TOP: assert property (@(posedge pclk) disable iff (!presetn)
        (st.state == dmba_pkg::DMBA_IDLE && dma_raised && mreq.req[1])
        |=> grant == 3'h2)
        else $error("Raised DMA not granted");

    // DMA beats debug in either order
    AST_DMA_OVER_DBG: assert property (@(posedge pclk) disable iff (!presetn)
        (st.state == dmba_pkg::DMBA_IDLE && mreq.req == 3'h6)
        |=> grant == 3'h2)
        else $error("DMA lost to debug");

    // Debug alone is still served
    AST_DBG_LAST: assert property (@(posedge pclk) disable iff (!presetn)
        (st.state == dmba_pkg::DMBA_IDLE && mreq.req == 3'h4)
        |=> grant == 3'h4)
        else $error("Lone debug not granted");

    // CPU beats debug in either order
    AST_CPU_OVER_DBG: assert property (@(posedge pclk) disable iff (!presetn)
        (st.state == dmba_pkg::DMBA_IDLE && mreq.req == 3'h5)
        |=> grant == 3'h1)
        else $error("CPU lost to debug");

    // No request, no owner
    AST_NO_REQ_NO_GRANT: assert property (@(posedge pclk) disable iff (!presetn)
        (st.state == dmba_pkg::DMBA_IDLE && mreq.req == 3'h0)
        |=> grant == 3'h0)
        else $error("Grant without any request");

    // A pending request while idle is decided at once
    AST_GRANT_FROM_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        s_decide |=> grant != 3'h0)
        else $error("Idle arbiter ignored a request");

    // Owner keeps the bus until its done pulse
    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (grant != 3'h0 && (mreq.done & grant) == 3'h0)
        |=> $stable(grant))
        else $error("Grant moved before done");

    // Done frees the bus for the idle decision cycle
    AST_RELEASE: assert property (@(posedge pclk) disable iff (!presetn)
        s_owner_done |=> (grant == 3'h0 && st.state == dmba_pkg::DMBA_IDLE))
        else $error("Grant kept after done");

    // A stalled loser is served right after the owner leaves
    AST_SERVE_LOSER: assert property (@(posedge pclk) disable iff (!presetn)
        s_owner_done ##1 s_decide |=> grant != 3'h0)
        else $error("Pending loser not served");

    // A full-strobe write lands at its completing edge
    AST_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && hit_prio && pstrb == 4'hf)
        |=> st.prio == $past(pwdata[15:0]))
        else $error("Priority write lost");

    // Priority changes only through a completed write
    AST_PRIO_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && penable && pready && pwrite && hit_prio)
        |=> $stable(st.prio))
        else $error("Priority changed without a write");

    // Read of the priority word shows it, upper half zero
    AST_READ_PRIO: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && hit_prio)
        |=> prdata == {16'h0000, st.prio})
        else $error("Priority read data wrong");

    // Unmapped address answers with an error
    AST_ERR_UNMAPPED: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !hit_prio && !hit_stat)
        |=> pslverr)
        else $error("Unmapped access not refused");

    // Mapped address answers without an error
    AST_NO_ERR_MAPPED: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && (hit_prio || hit_stat))
        |=> !pslverr)
        else $error("Mapped access refused");

    // Error shows only together with ready
    AST_ERR_WITH_READY: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("Error without ready");

    // Ready is one cycle, right after setup
    AST_READY: assert property (@(posedge pclk) disable iff (!presetn)
        s_setup |=> pready ##1 !pready)
        else $error("APB ready timing");

    // Ready drops after the completing edge
    AST_READY_DROP: assert property (@(posedge pclk) disable iff (!presetn)
        s_complete |=> !pready)
        else $error("Ready held after completion");

    // Per master: a grant goes only to a master that asked for it
    genvar gi;
    generate
        for (gi = 0; gi < `DMBA_NUM_MASTERS; gi++)
        begin : g_master
            AST_GRANT_REQ: assert property (@(posedge pclk) disable iff (!presetn)
                $rose(grant[gi]) |-> $past(mreq.req[gi]))
                else $error("Grant without request");
        end
    endgenerate
endmodule // dmba_arbiter

/* File: test/dmba_masters.sv */
// Behavioural model of the three bus masters facing the arbiter.
// Assumes a one-hot grant and one done pulse closing each access.
module dmba_masters (
    input  wire logic                 pclk,     // System clock
    input  wire logic                 presetn,  // Async reset, active low
    input  wire dmba_pkg::dmba_vec_t  go,       // Start a request per master
    input  wire logic [3:0]           hold,     // Extra cycles of ownership
    input  wire dmba_pkg::dmba_vec_t  grant,    // Owner from the arbiter
    output      dmba_pkg::dmba_mreq_t mreq      // Requests and done pulses
);
    logic [3:0] cnt;  // Cycles spent as owner

    // Keep requests up until done, finish after hold cycles
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mreq <= '0;
            cnt  <= '0;
        end
        else
        begin
            mreq.done <= '0;
            mreq.req  <= mreq.req | go;
            if ((grant & mreq.req) != '0 && mreq.done == '0)
            begin
                cnt <= (cnt == hold) ? 4'h0 : cnt + 4'h1;
                if (cnt == hold)
                begin
                    mreq.done <= grant;
                    mreq.req  <= (mreq.req | go) & ~grant;
                end
            end
        end
    end
endmodule // dmba_masters

/* File: test/tb_top.sv */
// Self-checking bench for the data memory bus arbiter.
// Assumes the master model drives requests and done pulses.
`include "dmba_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]          paddr;    // APB address
    logic [31:0]          pwdata, prdata, rd;
    logic [3:0]           hold;     // Slowness of the masters
    dmba_pkg::dmba_vec_t  go, grant, last_g;
    dmba_pkg::dmba_mreq_t mreq;
    dmba_pkg::dmba_vec_t  log_q[$]; // Owners in grant order
    int                   miscompares, checks_done, cycles;

    always #25 pclk = ~pclk;  // 20 MHz

    dmba_arbiter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mreq(mreq), .grant(grant));
    dmba_masters u_masters (.pclk(pclk), .presetn(presetn), .go(go), .hold(hold),
        .grant(grant), .mreq(mreq));

    // Log each new owner; cut a hang short
    always @(posedge pclk)
    begin
        cycles++;
        if (grant !== last_g && grant !== 3'h0) log_q.push_back(grant);
        last_g <= grant;
        if (cycles == 3000)
        begin
            miscompares++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pulse request starts for the chosen masters
    task automatic launch(input dmba_pkg::dmba_vec_t g);
        @(posedge pclk);
        go <= g;
        @(posedge pclk);
        go <= 3'h0;
        @(posedge pclk);
    endtask

    // Wait for all masters to finish, compare grant order
    task automatic finish(input logic [8:0] exp, input int n, input string name);
        int i;
        for (i = 0; i < 200 && (mreq.req !== 3'h0 || grant !== 3'h0); i++) @(posedge pclk);
        check(32'(log_q.size()), 32'(n));
        for (i = 0; i < n; i++) check({29'h0, log_q[i]}, {29'h0, exp[3*i+:3]});
        log_q.delete();
        $display("test %s done", name);
    endtask

    initial
    begin
        pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; go = 3'h0; hold = 4'h0; last_g = 3'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `DMBA_PRIO_CTRL_OFFSET, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        check({31'h0, err}, 32'h1);
        launch(3'h7);
        finish({3'h4, 3'h2, 3'h1}, 3, "default");
        apb(1'b1, `DMBA_PRIO_CTRL_OFFSET, {16'h0, `DMBA_PRIO_DMA_RAISED});
        apb(1'b0, `DMBA_PRIO_CTRL_OFFSET, 32'h0);
        check(rd, 32'h20);
        launch(3'h7);
        finish({3'h4, 3'h1, 3'h2}, 3, "raised");
        hold <= 4'ha;
        launch(3'h4);
        while (grant !== 3'h4) @(posedge pclk);
        apb(1'b0, `DMBA_STATUS_OFFSET, 32'h0);
        check(rd, 32'h24);
        apb(1'b1, `DMBA_PRIO_CTRL_OFFSET, 32'h0);
        launch(3'h3);
        finish({3'h2, 3'h1, 3'h4}, 3, "switch");
        apb(1'b1, `DMBA_PRIO_CTRL_OFFSET, {16'h0, `DMBA_PRIO_DMA_RAISED});
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `DMBA_PRIO_CTRL_OFFSET, 32'h0);
        check(rd, 32'h0);
        launch(3'h3);
        finish({3'h0, 3'h2, 3'h1}, 2, "reset");
        test_done();
    end
endmodule // tb_top
